// >>> core/program_memory_segment_guard.sv
// top of the segment guard: config registers, access decision, programmer entry gate
// assumes one 25 MHz clock; access requests come from logic on that clock,
// the programmer entry request is a pin and is synchronised here
// every verdict is registered: a request is answered one cycle later
// config words sit in flops; loading them at power-up is left outside
//
// The plain strobed port and the register offsets were left to the implementer.

`timescale 1ns/1ps
`include "segment_guard_cfg.svh"
module program_memory_segment_guard #(
    parameter int ADDR_W = 24,
    parameter int FLASH_PAGES = 512
) (
    input wire logic clk,
    input wire logic rstn,

    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,

    // access request from cores, programmer or image loader
    input wire logic acc_valid,
    input wire logic [ADDR_W-1:0] acc_addr,
    input wire logic [1:0] acc_kind,
    input wire logic [1:0] acc_src,
    input wire logic acc_to_ram,
    output logic acc_done,
    output logic acc_grant,
    output logic acc_deny,
    output logic [2:0] acc_segment,

    // programmer entry into secondary ram
    input wire logic ram_entry_req,
    output logic ram_entry_grant,
    output logic ram_entry_blocked
);
    // whole module state
    // one packed struct: reset and update reach every flop alike
    typedef struct packed {
        logic [15:0] security; // security_config_word
        logic [12:0] boot_pages; // boot_page_count
        logic [1:0] entry_sync; // pin synchroniser

        // register read data, stands one cycle
        logic [31:0] rdata;

        // access answer pulse and verdict
        logic done;
        logic grant;
        logic deny;

        // segment of the latest request, held
        logic [2:0] seg;

        logic [2:0] last_deny_seg; // segment of last refusal
        logic [15:0] deny_count; // saturating refusal count

        logic entry_grant;
        logic entry_blocked;
    } state_s;

    state_s cur_q;
    state_s nxt_d;

    // decoded configuration fields
    // views of the stored security word
    logic boot_wp;
    logic [1:0] boot_lvl;

    logic gen_wp;
    logic [1:0] gen_lvl;

    logic cfg_wp;
    logic [1:0] cfg_lvl;
    logic alt_table_en; // alternate_vector_table enabled

    // classifier and ram guard results
    // combinational, valid in the request cycle
    segment_guard_pkg::seg_e seg;
    logic boot_enabled;
    logic last_boot_page;
    logic alt_table_page; // last boot page holds the alternate table
    logic ram_blocked;
    logic ram_ok;

    // typed views of request fields
    // values outside the enums fall to default branches
    segment_guard_pkg::acc_e kind;
    segment_guard_pkg::src_e src;

    // field extraction from the security word
    // a level of zero leaves its segment open
    always_comb begin
        boot_wp = cur_q.security[`SG_BOOT_WP_BIT]; // R01
        boot_lvl = cur_q.security[`SG_BOOT_LVL_LSB +: 2];

        // general fields stand alone: no other segment is needed
        gen_wp = cur_q.security[`SG_GEN_WP_BIT]; // R13
        gen_lvl = cur_q.security[`SG_GEN_LVL_LSB +: 2];

        cfg_wp = cur_q.security[`SG_CFG_WP_BIT];
        cfg_lvl = cur_q.security[`SG_CFG_LVL_LSB +: 2];

        alt_table_en = cur_q.security[`SG_ALT_TABLE_EN_BIT];

        // request fields seen through the package types
        kind = segment_guard_pkg::acc_e'(acc_kind);
        src = segment_guard_pkg::src_e'(acc_src);
    end

    // address decode: segment, boot size, last boot page
    segment_classifier #(
        .ADDR_W(ADDR_W),
        .FLASH_PAGES(FLASH_PAGES)
    ) u_classify (
        .addr(acc_addr),
        .boot_page_count(cur_q.boot_pages),
        .alt_table_en(alt_table_en),
        .seg(seg),
        .boot_enabled(boot_enabled),
        .last_boot_page(last_boot_page),
        .alt_table_page(alt_table_page)
    );

    // the ram follows the general segment settings only
    // no boot or config split exists inside it
    ram_guard u_ram (
        .general_security_level(gen_lvl),
        .general_write_protect(gen_wp),
        .src(src),
        .kind(kind),
        .entry_blocked(ram_blocked),
        .access_ok(ram_ok)
    );

    // per-target protection values
    // taken from the segment the address falls in
    logic [1:0] tgt_lvl; // protect level of the target
    logic tgt_wp; // write protect of the target
    logic read_ok;
    logic write_ok;
    logic flash_ok;

    // level and write protect of the addressed segment
    always_comb begin
        tgt_lvl = 2'h0;
        tgt_wp = 1'b0;

        case (seg)
            // boot segment: its own level and write protect
            segment_guard_pkg::SEG_BOOT: begin
                tgt_lvl = boot_lvl;
                // alternate table page is outside boot write protect
                tgt_wp = boot_wp && !alt_table_page; // R06
            end
            // general segment: end-user code, lowest privilege
            segment_guard_pkg::SEG_GENERAL: begin
                tgt_lvl = gen_lvl;
                tgt_wp = gen_wp;
            end
            // configuration words on the top page
            segment_guard_pkg::SEG_CONFIG: begin
                tgt_lvl = cfg_lvl;
                tgt_wp = cfg_wp;
            end
            // vectors borrow a level; either write protect locks them
            segment_guard_pkg::SEG_VECTORS: begin
                tgt_lvl = boot_enabled ? boot_lvl : gen_lvl; // R09
                tgt_wp = boot_wp || gen_wp; // R10
            end
            // beyond the implemented flash
            default: begin
                tgt_lvl = 2'h3; // unmapped: treated as locked
                tgt_wp = 1'b1;
            end
        endcase
    end

    // privilege check: boot code sees every mapped page, general code its own segment and open ones
    always_comb begin
        case (src)
            // boot code: highest privilege, reads any mapped page
            segment_guard_pkg::SRC_BOOT_CODE: read_ok = 1'b1; // R12

            // general code: its own segment, or any open one
            segment_guard_pkg::SRC_GENERAL_CODE: begin
                read_ok = (seg == segment_guard_pkg::SEG_GENERAL)
                          || !segment_guard_pkg::is_secured(tgt_lvl); // R12
            end

            // programmer and loader: open segments only
            default: read_ok = !segment_guard_pkg::is_secured(tgt_lvl); // R01
        endcase

        // unmapped pages refuse every source
        if (seg == segment_guard_pkg::SEG_NONE) begin
            read_ok = 1'b0;
        end

        // a write needs the read right and no write protect
        write_ok = read_ok && !tgt_wp; // R01
        // boot code keeps the right to rework its last page;
        // the vector half of page zero stays under the vector lock
        if ((src == segment_guard_pkg::SRC_BOOT_CODE) && last_boot_page
            && (seg == segment_guard_pkg::SEG_BOOT)) begin
            write_ok = 1'b1; // R07
        end

        // program and erase share one right
        flash_ok = (kind == segment_guard_pkg::ACC_READ) ? read_ok : write_ok;
    end

    // next state: register port, access answer, entry gate
    always_comb begin
        nxt_d = cur_q;
        // answer pulses last one cycle; config and segment hold
        nxt_d.rdata = 32'h0000_0000;
        nxt_d.done = acc_valid;
        nxt_d.grant = 1'b0;
        nxt_d.deny = 1'b0;

        // register writes: configuration words
        // a write acts at this edge; a request here still sees old words
        if (reg_wr) begin
            case (reg_addr)
                `SG_OFF_SECURITY: nxt_d.security = reg_wdata[15:0];
                `SG_OFF_BOOT_LIMIT: nxt_d.boot_pages = reg_wdata[12:0]; // R02
                `SG_OFF_DENY_COUNT: nxt_d.deny_count = 16'h0000; // write clears
                // other offsets, status included, ignore writes
                default: ;
            endcase
        end

        // register reads: data stand only in the following cycle
        if (reg_rd) begin
            case (reg_addr)
                `SG_OFF_SECURITY: nxt_d.rdata = {16'h0000, cur_q.security};
                `SG_OFF_BOOT_LIMIT: nxt_d.rdata = {19'h0_0000, cur_q.boot_pages};
                `SG_OFF_STATUS: begin
                    nxt_d.rdata = {24'h00_0000, cur_q.entry_blocked, boot_enabled,
                                   alt_table_en, 2'h0, cur_q.last_deny_seg};
                end
                `SG_OFF_DENY_COUNT: nxt_d.rdata = {16'h0000, cur_q.deny_count};
                default: nxt_d.rdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end

        // access decision, answered one cycle after the request
        if (acc_valid) begin
            if (acc_to_ram) begin
                // the ram has no segments: reported as general
                nxt_d.grant = ram_ok; // R15
                nxt_d.seg = 3'(segment_guard_pkg::SEG_GENERAL);
            end else begin
                nxt_d.grant = flash_ok; // R18
                nxt_d.seg = 3'(seg);
            end

            // exactly one of grant and deny rides with done
            nxt_d.deny = !nxt_d.grant;
            if (!nxt_d.grant) begin
                nxt_d.last_deny_seg = nxt_d.seg;
                // a refusal in the same cycle as a clear still counts
                if (nxt_d.deny_count != 16'hFFFF) begin
                    nxt_d.deny_count = nxt_d.deny_count + 16'h0001;
                end
            end
        end

        // programmer entry pin, two flops before use
        // a grant drops as soon as protection is switched on
        nxt_d.entry_sync = {cur_q.entry_sync[0], ram_entry_req};
        nxt_d.entry_blocked = ram_blocked; // R16
        nxt_d.entry_grant = cur_q.entry_sync[1] && !ram_blocked; // R16
    end

    // state register
    // async reset: config words open, boot segment disabled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_q <= '{security: `SG_SECURITY_RESET, boot_pages: `SG_BOOT_LIMIT_RESET,
                       default: '0};
        end else begin
            // the whole state advances in one assignment
            cur_q <= nxt_d;
        end
    end

    // outputs straight from flops
    always_comb begin
        reg_rdata = cur_q.rdata;

        acc_done = cur_q.done;
        acc_grant = cur_q.grant;
        acc_deny = cur_q.deny;
        acc_segment = cur_q.seg;

        ram_entry_grant = cur_q.entry_grant;
        ram_entry_blocked = cur_q.entry_blocked;
    end

endmodule : program_memory_segment_guard

// >>> core/ram_guard.sv
// security of the secondary core program ram, taken from general segment settings
// assumes the programmer entry request is already synchronised
`timescale 1ns/1ps
module ram_guard (
    input wire logic [1:0] general_security_level,
    input wire logic general_write_protect,
    input wire segment_guard_pkg::src_e src,
    input wire segment_guard_pkg::acc_e kind,
    output logic entry_blocked,
    output logic access_ok
);
    // no boot or config split inside the ram: one general rule for all of it
    always_comb begin
        entry_blocked = segment_guard_pkg::is_secured(general_security_level)
                        || general_write_protect; // R14 R16
        case (src)
            // image load by the primary core is never stopped
            segment_guard_pkg::SRC_IMAGE_LOADER: access_ok = 1'b1; // R17
            // outside tool: reads and writes stopped while entry is blocked
            segment_guard_pkg::SRC_PROGRAMMER: access_ok = !entry_blocked; // R16
            // running code: writes follow the general write protect
            default: access_ok = (kind == segment_guard_pkg::ACC_READ)
                                 || !general_write_protect; // R15
        endcase
    end

endmodule : ram_guard

// >>> core/segment_classifier.sv
// maps a flash word address to its security segment
// assumes config words are stable for the duration of a lookup
`timescale 1ns/1ps
`include "segment_guard_cfg.svh"
module segment_classifier #(
    parameter int ADDR_W = 24,
    parameter int FLASH_PAGES = 512
) (
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [12:0] boot_page_count,
    input wire logic alt_table_en,
    output segment_guard_pkg::seg_e seg,
    output logic boot_enabled,
    output logic last_boot_page,
    output logic alt_table_page
);
    localparam int PAGE_W = ADDR_W - `SG_PAGE_WORDS_LOG2;

    logic [PAGE_W-1:0] page; // 1024-word page index
    logic [12:0] eff_pages; // boot pages after minimum rules
    logic [PAGE_W-1:0] boot_end; // first page past the boot segment
    logic in_vectors; // low half of page zero

    // page index and effective boot size
    always_comb begin
        page = addr[ADDR_W-1:`SG_PAGE_WORDS_LOG2]; // R02
        in_vectors = (page == '0)
                     && (addr[`SG_PAGE_WORDS_LOG2-1:`SG_VECTOR_WORDS_LOG2] == 1'b0); // R03
        eff_pages = boot_page_count;
        // the alternate table needs its own page beside the vectors
        if (alt_table_en && (boot_page_count != 13'h0000)
            && (boot_page_count < `SG_ALT_TABLE_MIN_PAGES)) begin
            eff_pages = `SG_ALT_TABLE_MIN_PAGES; // R05
        end
        boot_enabled = (boot_page_count != 13'h0000);
        boot_end = PAGE_W'(eff_pages);
    end

    // segment decision by page comparison
    always_comb begin
        last_boot_page = boot_enabled && (page == boot_end - PAGE_W'(1));
        alt_table_page = alt_table_en && last_boot_page; // R04
        if (page >= PAGE_W'(FLASH_PAGES)) begin
            seg = segment_guard_pkg::SEG_NONE; // beyond flash
        end else if (page == PAGE_W'(FLASH_PAGES - 1)) begin
            seg = segment_guard_pkg::SEG_CONFIG; // R11
        end else if (in_vectors) begin
            seg = segment_guard_pkg::SEG_VECTORS; // vectors handled apart
        end else if (boot_enabled && (page < boot_end)) begin
            seg = segment_guard_pkg::SEG_BOOT; // R18
        end else begin
            seg = segment_guard_pkg::SEG_GENERAL; // R08
        end
    end

endmodule : segment_classifier

// >>> dv/access_agent.sv
// far side model: cores, image loader and serial programmer
// assumes tasks are called from one bench process, synchronous to clk
`timescale 1ns/1ps
module access_agent (
    input wire logic clk,
    output logic acc_valid,
    output logic [23:0] acc_addr,
    output logic [1:0] acc_kind,
    output logic [1:0] acc_src,
    output logic acc_to_ram,
    output logic ram_entry_req
);
    // idle from time zero
    initial begin
        acc_valid = 1'b0;
        acc_addr = 24'h00_0000;
        acc_kind = 2'h0;
        acc_src = 2'h0;
        acc_to_ram = 1'b0;
        ram_entry_req = 1'b0;
    end
    // one request per call; calls may follow with no gap
    task automatic issue(input logic [23:0] a, input logic [1:0] k, input logic [1:0] s,
                         input logic r);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_kind <= k;
        acc_src <= s;
        acc_to_ram <= r;
    endtask : issue
    // release: stale address and source scrambled so nobody leans on them
    task automatic quiet();
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_addr <= ~acc_addr;
        acc_src <= ~acc_src;
    endtask : quiet
    // programmer entry pin, a level held until dropped
    task automatic entry(input logic lvl);
        @(posedge clk);
        ram_entry_req <= lvl;
    endtask : entry
endmodule : access_agent

// >>> dv/program_memory_segment_guard_asserts.sv
// checker for the segment guard top: verdict timing and fixed grants
// assumes it is bound to the top and sees only its ports
`timescale 1ns/1ps
module segment_guard_checker #(
    parameter int ADDR_W = 24,
    parameter int FLASH_PAGES = 512
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic acc_valid,
    input wire logic [ADDR_W-1:0] acc_addr,
    input wire logic [1:0] acc_kind,
    input wire logic [1:0] acc_src,
    input wire logic acc_to_ram,
    input wire logic acc_done,
    input wire logic acc_grant,
    input wire logic acc_deny,
    input wire logic [2:0] acc_segment,
    input wire logic ram_entry_req,
    input wire logic ram_entry_grant,
    input wire logic ram_entry_blocked
);
    // page index inside the implemented flash
    logic page_ok;
    assign page_ok = 32'(acc_addr[ADDR_W-1:10]) < FLASH_PAGES;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    done_next_cycle_a: assert property (acc_valid |=> acc_done)
        else $error("request not answered one cycle later");
    done_has_cause_a: assert property (acc_done |-> $past(acc_valid))
        else $error("answer without a request");
    one_verdict_a: assert property (acc_done |-> acc_grant != acc_deny)
        else $error("grant and deny not exclusive");
    quiet_verdict_a: assert property (!acc_done |-> !acc_grant && !acc_deny)
        else $error("verdict outside answer cycle");
    unmapped_refused_a: assert property (
        acc_valid && !acc_to_ram && !page_ok |=> acc_deny && acc_segment == 3'h4)
        else $error("unmapped page not refused");
    boot_reads_all_a: assert property (
        acc_valid && !acc_to_ram && page_ok && acc_src == 2'h0 && acc_kind == 2'h0
        |=> acc_grant) else $error("boot code read refused");
    loader_always_a: assert property (
        acc_valid && acc_to_ram && acc_src == 2'h3 |=> acc_grant)
        else $error("image load refused");
    ram_reads_open_a: assert property (
        acc_valid && acc_to_ram && acc_kind == 2'h0 && acc_src inside {2'h0, 2'h1}
        |=> acc_grant && acc_segment == 3'h1) else $error("core read of ram refused");
    entry_gate_a: assert property (ram_entry_blocked [*2] |-> !ram_entry_grant)
        else $error("entry granted while blocked");
    entry_latency_a: assert property (ram_entry_grant |-> $past(ram_entry_req, 3))
        else $error("entry grant without synced request");
    segment_holds_a: assert property (!$past(acc_valid) |-> $stable(acc_segment))
        else $error("segment changed without request");

    // main scenarios reached
    cover property (acc_done && acc_deny);
    cover property (acc_valid ##1 acc_valid);
    cover property (ram_entry_grant);
endmodule : segment_guard_checker

bind program_memory_segment_guard segment_guard_checker #(
    .ADDR_W(ADDR_W), .FLASH_PAGES(FLASH_PAGES)
) checker_i (
    .clk(clk), .rstn(rstn), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_kind(acc_kind), .acc_src(acc_src), .acc_to_ram(acc_to_ram),
    .acc_done(acc_done), .acc_grant(acc_grant), .acc_deny(acc_deny),
    .acc_segment(acc_segment), .ram_entry_req(ram_entry_req),
    .ram_entry_grant(ram_entry_grant), .ram_entry_blocked(ram_entry_blocked)
);

// >>> dv/test_program_memory_segment_guard.sv
// self-checking bench for the segment guard top
// assumes the agent drives the access side; registers driven here
`timescale 1ns/1ps
`include "segment_guard_cfg.svh"
module test_program_memory_segment_guard;
    localparam int PAGES = 16; // small flash keeps the config page near
    localparam logic [1:0] RD = 2'h0, PR = 2'h1, ER = 2'h2;
    localparam logic [1:0] B = 2'h0, G = 2'h1, P = 2'h2, L = 2'h3;
    logic clk, rstn, reg_wr, reg_rd, rd_pend;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic acc_valid, acc_to_ram, acc_done, acc_grant, acc_deny;
    logic [23:0] acc_addr;
    logic [1:0] acc_kind, acc_src;
    logic [2:0] acc_segment;
    logic ram_entry_req, ram_entry_grant, ram_entry_blocked;
    logic [3:0] acc_exp; // grant flag and segment, 7 = any segment
    logic [3:0] acc_q[$];
    logic [31:0] rd_q[$];
    int miscompares, checks_done;

    program_memory_segment_guard #(.ADDR_W(24), .FLASH_PAGES(PAGES)) DUT (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind),
        .acc_src(acc_src), .acc_to_ram(acc_to_ram), .acc_done(acc_done),
        .acc_grant(acc_grant), .acc_deny(acc_deny), .acc_segment(acc_segment),
        .ram_entry_req(ram_entry_req), .ram_entry_grant(ram_entry_grant),
        .ram_entry_blocked(ram_entry_blocked));
    access_agent agent (
        .clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind),
        .acc_src(acc_src), .acc_to_ram(acc_to_ram), .ram_entry_req(ram_entry_req));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // one-cycle register strobes, always apart by one idle cycle
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : reg_read

    // note the verdict, then hand the request to the agent
    task automatic acc(input logic [23:0] a, input logic [1:0] k, input logic [1:0] s,
                       input logic r, input logic g, input logic [2:0] sg);
        acc_q.push_back({g, sg});
        agent.issue(a, k, s, r);
    endtask : acc
    // close a test and load the next configuration
    task automatic cfg(input string name, input logic [31:0] sec, input logic [31:0] cnt);
        agent.quiet();
        $display("test %s done", name);
        reg_write(`SG_OFF_SECURITY, sec);
        reg_write(`SG_OFF_BOOT_LIMIT, cnt);
    endtask : cfg
    // random offset inside a page; offset never matters away from page 0
    function automatic logic [23:0] pg(input int p);
        pg = {p[13:0], 10'($urandom())};
    endfunction : pg

    // monitor: oldest note against each answer
    always @(posedge clk) begin
        if (acc_done === 1'b1) begin
            acc_exp = acc_q.pop_front();
            check("acc_grant", 32'(acc_grant), 32'(acc_exp[3]));
            check("acc_deny", 32'(acc_deny), 32'(!acc_exp[3]));
            if (acc_exp[2:0] != 3'h7) begin
                check("acc_segment", 32'(acc_segment), 32'(acc_exp[2:0]));
            end
        end
        if (rd_pend) begin
            check("reg_rdata", reg_rdata, rd_q.pop_front());
        end
        rd_pend = reg_rd;
    end

    // hang guard
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        $display("ERROR watchdog expired");
        conclude();
    end

    initial begin
        {rstn, reg_wr, reg_rd} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        void'($urandom(32'hede92ced));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        agent.entry(1'b1);
        acc(pg(3), RD, P, 1'b0, 1'b1, 3'h1);
        acc(24'h00_0010, PR, G, 1'b0, 1'b1, 3'h3);
        acc(pg(PAGES - 1), RD, P, 1'b0, 1'b1, 3'h2);
        acc(pg(PAGES), RD, B, 1'b0, 1'b0, 3'h4);
        check("entry_grant", 32'(ram_entry_grant), 32'h0000_0001);
        cfg("open", 32'h0000_0020, 32'h0000_0002);
        acc(pg(3), RD, P, 1'b0, 1'b0, 3'h1);
        acc(pg(3), RD, G, 1'b0, 1'b1, 3'h1);
        acc(pg(3), RD, B, 1'b0, 1'b1, 3'h1);
        acc(pg(1), RD, P, 1'b0, 1'b1, 3'h0);
        acc(pg(2), RD, P, 1'b0, 1'b0, 3'h1);
        acc(24'h00_0010, RD, P, 1'b0, 1'b1, 3'h3);
        acc(pg(5), RD, P, 1'b1, 1'b0, 3'h1);
        acc(pg(5), PR, L, 1'b1, 1'b1, 3'h1);
        acc(pg(5), RD, G, 1'b1, 1'b1, 3'h1);
        check("entry_blocked", 32'(ram_entry_blocked), 32'h0000_0001);
        check("entry_grant", 32'(ram_entry_grant), 32'h0000_0000);
        cfg("general level", 32'h0000_0001, 32'h0000_0002);
        acc(24'h00_0010, PR, G, 1'b0, 1'b0, 3'h3);
        acc(pg(1), ER, B, 1'b0, 1'b1, 3'h0);
        acc(24'h00_0200, PR, B, 1'b0, 1'b0, 3'h0);
        acc(pg(3), PR, G, 1'b0, 1'b1, 3'h1);
        cfg("boot protect", 32'h0000_1021, 32'h0000_0001);
        acc(pg(1), ER, G, 1'b0, 1'b1, 3'h7);
        acc(pg(1), RD, P, 1'b0, 1'b1, 3'h7);
        acc(pg(2), RD, P, 1'b0, 1'b0, 3'h1);
        cfg("alternate table", 32'h0000_0010, 32'h0000_0001);
        reg_write(`SG_OFF_DENY_COUNT, 32'h0000_0000);
        acc(pg(3), PR, G, 1'b0, 1'b0, 3'h1);
        acc(24'h00_0010, ER, B, 1'b0, 1'b0, 3'h3);
        acc(pg(4), PR, G, 1'b1, 1'b0, 3'h1);
        acc(pg(4), ER, L, 1'b1, 1'b1, 3'h1);
        acc(pg(4), RD, B, 1'b1, 1'b1, 3'h1);
        agent.quiet();
        check("entry_blocked", 32'(ram_entry_blocked), 32'h0000_0001);
        reg_read(`SG_OFF_DENY_COUNT, 32'h0000_0003);
        reg_read(`SG_OFF_SECURITY, 32'h0000_0010);
        reg_read(`SG_OFF_BOOT_LIMIT, 32'h0000_0001);
        reg_read(8'h20, 32'h0000_0000);
        reg_read(`SG_OFF_STATUS, 32'h0000_00C1);
        for (int i = 0; i < 20 && (acc_q.size() + rd_q.size()) > 0; i++) begin
            @(posedge clk);
        end
        if ((acc_q.size() + rd_q.size()) > 0) begin
            miscompares++;
            $display("ERROR answers missing");
        end
        $display("test write protect done");
        conclude();
    end
endmodule : test_program_memory_segment_guard

// >>> inc/segment_guard_cfg.svh
// constants for the program memory segment guard: offsets, field positions, reset values
// assumes a 24-bit instruction word address and a plain one-cycle register port
//
// Functional notes
// R01: per-segment protect level and write protect enforced
// R02: boot size is page count, 1024-word pages
// R03: one boot page holds vectors plus code
// R04: alternate table occupies last boot page
// R05: alternate table forces two boot pages minimum
// R06: boot write protect spares alternate table page
// R07: boot code may always rewrite last page; the code keeps the vector half of page zero under the vector lock
// R08: general segment follows boot, up to config
// R09: vector table takes general level without boot
// R10: vector table locked if any write protect; the code ignores config write protect here
// R11: config segment is the top page only
// R12: boot most privileged, general least privileged
// R13: general protection stands independent of others
// R14: ram security follows general level and protect
// R15: ram is all general segment, no sub-segments
// R16: protected general blocks programmer entry to ram
// R17: primary core image load always allowed
// R18: classify address by page versus boot count
`ifndef SEGMENT_GUARD_CFG_SVH
`define SEGMENT_GUARD_CFG_SVH

// register offsets (byte addresses)
`define SG_OFF_SECURITY 8'h00
`define SG_OFF_BOOT_LIMIT 8'h04
`define SG_OFF_STATUS 8'h08
`define SG_OFF_DENY_COUNT 8'h0C

// security_config_word field positions
`define SG_BOOT_WP_BIT 0
`define SG_BOOT_LVL_LSB 1
`define SG_GEN_WP_BIT 4
`define SG_GEN_LVL_LSB 5
`define SG_CFG_WP_BIT 8
`define SG_CFG_LVL_LSB 9
`define SG_ALT_TABLE_EN_BIT 12

// reset values: everything open, boot segment disabled
`define SG_SECURITY_RESET 16'h0000
`define SG_BOOT_LIMIT_RESET 13'h0000

// memory geometry
`define SG_PAGE_WORDS_LOG2 10
`define SG_VECTOR_WORDS_LOG2 9
`define SG_ALT_TABLE_MIN_PAGES 13'h0002

`endif

// >>> inc/segment_guard_pkg.sv
// types shared by the segment guard modules
// assumes segment_guard_cfg.svh is included by the users of the constants
package segment_guard_pkg;

    // which segment an address falls in
    typedef enum logic [2:0] {
        SEG_BOOT,
        SEG_GENERAL,
        SEG_CONFIG,
        SEG_VECTORS,
        SEG_NONE
    } seg_e;

    // kind of memory access
    typedef enum logic [1:0] {
        ACC_READ,
        ACC_PROGRAM,
        ACC_ERASE
    } acc_e;

    // who issues the access
    typedef enum logic [1:0] {
        SRC_BOOT_CODE,
        SRC_GENERAL_CODE,
        SRC_PROGRAMMER,
        SRC_IMAGE_LOADER
    } src_e;

    // any non-zero level counts as code protected
    function automatic logic is_secured(input logic [1:0] level);
        is_secured = (level != 2'h0);
    endfunction : is_secured

endpackage : segment_guard_pkg
